// File: dpll_mode_ref_select_pkg.sv
// constants and types for the loop mode and reference select block
// How it works
// RQ1 - mode bits 1:0: 00 freerun, 01 holdover, 10 forced reference, 11 automatic
// RQ2 - automatic mode picks its reference from availability and programmed priority
// RQ3 - automatic mode enters holdover only when no reference is available
// RQ4 - forced reference mode locks to the reference named by bits 7:6
// RQ5 - forced reference failing gives holdover, never a switch to another one
// RQ6 - forced holdover ignores all references, keeping the last selected one
// RQ7 - freerun derives every output clock from the crystal oscillator only
// RQ8 - bit 5 set uses measured feedback phase for delay compensation, else ignored
// RQ9 - one shared feedback phase is used whichever loop made it
// RQ10 - automatic mode: bits 7:6 read back the selected reference, 00 is reference zero
// RQ11 - forced mode: bits 7:6 select reference zero to three by codes 00 to 11
// RQ12 - freerun and forced holdover ignore the reference select field
// RQ13 - holdover enable bit low stops that failure type forcing holdover
// RQ14 - software never writes holdover enable bits 3:1 as 100
// RQ15 - switch enable bit low stops that failure type causing a reference switch
// RQ16 - lower priority wins, revertive across levels, equal levels stay, 111 disables
// RQ17 - automatic mode ignores select writes; reads give the reference in use
package dpll_mode_ref_select_pkg;

    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] IDX_MODE_REFSEL = 8'h33;
    localparam logic [7:0] IDX_FAIL_MASK = 8'h34;
    localparam logic [9:0] ADDR_MODE_REFSEL = {IDX_MODE_REFSEL, 2'b00};
    localparam logic [9:0] ADDR_FAIL_MASK = {IDX_FAIL_MASK, 2'b00};

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int MODE_LSB = 0;
    localparam int RSV_LSB = 2;
    localparam int FB_EN_BIT = 5;
    localparam int SEL_LSB = 6;
    localparam int HOLD_LSB = 0;
    localparam int SWITCH_LSB = 4;
    localparam logic [7:0] RST_MODE_REFSEL = 8'h0f;
    localparam logic [7:0] RST_FAIL_MASK = 8'h87;
    localparam logic [2:0] PRIO_DISABLED = 3'h7;
    localparam int NUM_REFS = 4;

    // fault vector order inside each reference
    localparam int FLT_ABSENT = 0;
    localparam int FLT_SINGLE = 1;
    localparam int FLT_COARSE = 2;
    localparam int FLT_GUARD = 3;

    typedef enum logic [1:0] {
        MODE_FREERUN = 2'h0,
        MODE_HOLDOVER = 2'h1,
        MODE_FORCED = 2'h2,
        MODE_AUTO = 2'h3
    } loop_mode_t;

    typedef enum logic [2:0] {
        ST_FREERUN = 3'b001,
        ST_HOLDOVER = 3'b010,
        ST_LOCKED = 3'b100
    } loop_state_t;

endpackage : dpll_mode_ref_select_pkg

// File: ref_fault_qualify.sv
// fault synchroniser and mask qualification for one reference input
`timescale 1ns/1ps
module ref_fault_qualify
    import dpll_mode_ref_select_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] faults_i,
    input wire logic [3:0] hold_en_i,
    input wire logic [3:0] switch_en_i,
    output logic [3:0] faults_o,
    output logic hold_fail_o,
    output logic switch_fail_o
);

    logic [3:0] meta_q;
    logic [3:0] sync_q;

    // two stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= faults_i;
            sync_q <= meta_q;
        end
    end

    assign faults_o = sync_q;
    // RQ13 holdover enable gating
    assign hold_fail_o = |(sync_q & hold_en_i);
    // RQ15 switch enable gating
    assign switch_fail_o = |(sync_q & switch_en_i);

endmodule : ref_fault_qualify

// File: ref_best_pick.sv
// picks the best available reference by priority number
`timescale 1ns/1ps
module ref_best_pick
    import dpll_mode_ref_select_pkg::*;
(
    input wire logic [3:0] avail_i,
    input wire logic [11:0] prio_i,
    output logic any_o,
    output logic [1:0] best_idx_o,
    output logic [2:0] best_prio_o
);

    // RQ16 lowest number wins, ties go to lowest index
    always_comb begin
        any_o = 1'b0;
        best_idx_o = 2'h0;
        best_prio_o = PRIO_DISABLED;
        for (int i = 0; i < NUM_REFS; i++) begin
            if (avail_i[i] && (!any_o || prio_i[3*i +: 3] < best_prio_o)) begin
                any_o = 1'b1;
                best_idx_o = 2'(i);
                best_prio_o = prio_i[3*i +: 3];
            end
        end
    end

endmodule : ref_best_pick

// File: dpll_mode_ref_select.sv
// loop mode, reference selection and failure mask control with apb registers
`timescale 1ns/1ps
module dpll_mode_ref_select
    import dpll_mode_ref_select_pkg::*;
#(
    parameter int PHASE_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [9:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [3:0] signal_absent_fault_i,
    input wire logic [3:0] single_cycle_fault_i,
    input wire logic [3:0] coarse_frequency_fault_i,
    input wire logic [3:0] guard_timer_fault_i,
    input wire logic [11:0] ref_priority_i,
    input wire logic [PHASE_W-1:0] ext_fb_phase_i,
    output logic freerun_o,
    output logic holdover_o,
    output logic ref_locked_o,
    output logic [1:0] active_ref_o,
    output logic [3:0] ref_available_o,
    output logic ext_fb_used_o,
    output logic [PHASE_W-1:0] fb_phase_comp_o
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    loop_mode_t loop_operating_mode_q;
    logic external_feedback_enable_q;
    logic [1:0] forced_sel_q;
    logic [3:0] holdover_failure_enables_q;
    logic [3:0] switch_failure_enables_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // ----------------------------------------
    // loop state
    // ----------------------------------------
    loop_state_t state_q;
    loop_state_t state_d;
    logic [1:0] cur_ref_q;
    logic [1:0] cur_ref_d;
    logic [3:0] avail_q;
    logic [PHASE_W-1:0] fb_phase_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic apb_setup;
    logic apb_access;
    logic hit_mode;
    logic hit_mask;
    logic wr_mode;
    logic wr_mask;
    logic [7:0] mode_rd;
    logic [7:0] mask_rd;
    logic [31:0] rd_d;
    logic [1:0] wr_mode_field;

    // zero wait state slave, data captured in setup phase
    assign apb_setup = psel_i & ~penable_i;
    assign apb_access = psel_i & penable_i;
    assign hit_mode = (paddr_i == ADDR_MODE_REFSEL);
    assign hit_mask = (paddr_i == ADDR_FAIL_MASK);
    assign wr_mode = apb_access & pwrite_i & pstrb_i[0] & hit_mode;
    assign wr_mask = apb_access & pwrite_i & pstrb_i[0] & hit_mask;
    assign wr_mode_field = pwdata_i[MODE_LSB +: 2];
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q & apb_access;

    // ----------------------------------------
    // read data assembly
    // ----------------------------------------
    logic [1:0] sel_rd;

    // RQ10 status view in automatic mode
    // RQ17 read back the reference in use
    assign sel_rd = (loop_operating_mode_q == MODE_AUTO) ? cur_ref_q : forced_sel_q;
    assign mode_rd = {sel_rd, external_feedback_enable_q,
                      RST_MODE_REFSEL[RSV_LSB +: 3], loop_operating_mode_q};
    assign mask_rd = {switch_failure_enables_q, holdover_failure_enables_q};
    assign rd_d = hit_mode ? {24'h0, mode_rd} :
                  hit_mask ? {24'h0, mask_rd} : 32'h0;

    // read data and error captured at setup
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q <= pwrite_i ? 32'h0 : rd_d;
            pslverr_q <= ~(hit_mode | hit_mask);
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic sel_wr_ok;

    // RQ17 select writes ignored while automatic stays
    assign sel_wr_ok = (loop_operating_mode_q != MODE_AUTO) || (wr_mode_field != MODE_AUTO);

    // mode register write
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            loop_operating_mode_q <= loop_mode_t'(RST_MODE_REFSEL[MODE_LSB +: 2]);
            external_feedback_enable_q <= RST_MODE_REFSEL[FB_EN_BIT];
            forced_sel_q <= RST_MODE_REFSEL[SEL_LSB +: 2];
        end else if (wr_mode) begin
            loop_operating_mode_q <= loop_mode_t'(wr_mode_field);
            external_feedback_enable_q <= pwdata_i[FB_EN_BIT];
            // RQ11 forced select control field
            if (sel_wr_ok) begin
                forced_sel_q <= pwdata_i[SEL_LSB +: 2];
            end
        end
    end

    // failure mask register write
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            holdover_failure_enables_q <= RST_FAIL_MASK[HOLD_LSB +: 4];
            switch_failure_enables_q <= RST_FAIL_MASK[SWITCH_LSB +: 4];
        end else if (wr_mask) begin
            // RQ14 software keeps 3:1 away from 100
            holdover_failure_enables_q <= pwdata_i[HOLD_LSB +: 4];
            switch_failure_enables_q <= pwdata_i[SWITCH_LSB +: 4];
        end
    end

    // ----------------------------------------
    // per reference fault qualification
    // ----------------------------------------
    logic [3:0] hold_fail;
    logic [3:0] switch_fail;
    logic [3:0] ref_off;
    logic [3:0] avail;

    for (genvar r = 0; r < NUM_REFS; r++) begin : g_ref
        logic [3:0] flt;
        assign flt[FLT_ABSENT] = signal_absent_fault_i[r];
        assign flt[FLT_SINGLE] = single_cycle_fault_i[r];
        assign flt[FLT_COARSE] = coarse_frequency_fault_i[r];
        assign flt[FLT_GUARD] = guard_timer_fault_i[r];
        ref_fault_qualify u_qual (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .faults_i(flt),
            .hold_en_i(holdover_failure_enables_q),
            .switch_en_i(switch_failure_enables_q),
            .faults_o(),
            .hold_fail_o(hold_fail[r]),
            .switch_fail_o(switch_fail[r])
        );
        // RQ16 code 111 disables the reference
        assign ref_off[r] = (ref_priority_i[3*r +: 3] == PRIO_DISABLED);
        // RQ2 availability from faults and priority
        assign avail[r] = ~hold_fail[r] & ~switch_fail[r] & ~ref_off[r];
    end

    // ----------------------------------------
    // best reference
    // ----------------------------------------
    logic any_avail;
    logic [1:0] best_idx;
    logic [2:0] best_prio;
    logic [2:0] cur_prio;
    logic cur_leave;
    logic cur_revert;

    ref_best_pick u_pick (
        .avail_i(avail),
        .prio_i(ref_priority_i),
        .any_o(any_avail),
        .best_idx_o(best_idx),
        .best_prio_o(best_prio)
    );

    // RQ15 leave current on an enabled switch failure or on priority 111
    assign cur_prio = ref_priority_i[3*cur_ref_q +: 3];
    assign cur_leave = switch_fail[cur_ref_q] | ref_off[cur_ref_q];
    // RQ16 revert only to a strictly better priority
    assign cur_revert = avail[cur_ref_q] & (best_prio < cur_prio);

    // ----------------------------------------
    // mode and selection next state
    // ----------------------------------------
    // RQ1 mode decode
    always_comb begin
        state_d = state_q;
        cur_ref_d = cur_ref_q;
        unique case (loop_operating_mode_q)
            MODE_FREERUN: begin
                // RQ7 crystal only, RQ12 select ignored
                state_d = ST_FREERUN;
            end
            MODE_HOLDOVER: begin
                // RQ6 hold last reference history
                state_d = ST_HOLDOVER;
            end
            MODE_FORCED: begin
                // RQ4 lock the programmed reference
                cur_ref_d = forced_sel_q;
                // RQ5 failure means holdover, no switch
                state_d = hold_fail[forced_sel_q] ? ST_HOLDOVER : ST_LOCKED;
            end
            MODE_AUTO: begin
                // RQ3 holdover only with nothing available
                if (!any_avail) begin
                    state_d = ST_HOLDOVER;
                end else if (state_q != ST_LOCKED || cur_leave || cur_revert) begin
                    // RQ2 take the best available reference
                    state_d = ST_LOCKED;
                    cur_ref_d = best_idx;
                end else begin
                    state_d = ST_LOCKED;
                end
            end
        endcase
    end

    // loop state registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= ST_FREERUN;
            cur_ref_q <= 2'h0;
            avail_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cur_ref_q <= cur_ref_d;
            avail_q <= avail;
        end
    end

    // ----------------------------------------
    // external feedback compensation
    // ----------------------------------------
    // RQ8 feedback phase used only when enabled
    // RQ9 single shared phase whatever its source
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fb_phase_q <= '0;
        end else begin
            fb_phase_q <= external_feedback_enable_q ? ext_fb_phase_i : '0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign freerun_o = (state_q == ST_FREERUN);
    assign holdover_o = (state_q == ST_HOLDOVER);
    assign ref_locked_o = (state_q == ST_LOCKED);
    assign active_ref_o = cur_ref_q;
    assign ref_available_o = avail_q;
    assign ext_fb_used_o = external_feedback_enable_q;
    assign fb_phase_comp_o = fb_phase_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    logic fsel_fail;
    assign fsel_fail = hold_fail[forced_sel_q];

    a_freerun_mode: assert property ( // RQ7
        loop_operating_mode_q == MODE_FREERUN |=> freerun_o && !ref_locked_o)
        else $error("freerun mode did not give freerun state");

    a_forced_holdover: assert property ( // RQ6
        loop_operating_mode_q == MODE_HOLDOVER |=> holdover_o && $stable(active_ref_o))
        else $error("forced holdover left holdover or changed reference");

    a_forced_lock: assert property ( // RQ4
        loop_operating_mode_q == MODE_FORCED && !fsel_fail
        |=> ref_locked_o && active_ref_o == $past(forced_sel_q))
        else $error("forced mode not locked to selected reference");

    a_forced_fail: assert property ( // RQ5
        loop_operating_mode_q == MODE_FORCED && fsel_fail
        |=> holdover_o && active_ref_o == $past(forced_sel_q))
        else $error("forced reference failure did not give holdover");

    a_auto_none: assert property ( // RQ3
        loop_operating_mode_q == MODE_AUTO && avail == 4'h0 |=> holdover_o)
        else $error("automatic mode with no reference not in holdover");

    a_auto_some: assert property ( // RQ3
        loop_operating_mode_q == MODE_AUTO && avail != 4'h0 |=> ref_locked_o)
        else $error("automatic mode entered holdover with a reference up");

    a_auto_revert: assert property ( // RQ16
        loop_operating_mode_q == MODE_AUTO && ref_locked_o && cur_revert
        |=> active_ref_o == $past(best_idx))
        else $error("no revert to better priority reference");

    a_hold_masked: assert property ( // RQ13
        loop_operating_mode_q == MODE_FORCED && holdover_failure_enables_q == 4'h0
        |=> ref_locked_o)
        else $error("masked failures still forced holdover");

    a_status_read: assert property ( // RQ10
        apb_setup && !pwrite_i && hit_mode && loop_operating_mode_q == MODE_AUTO
        |=> prdata_o[SEL_LSB +: 2] == $past(cur_ref_q))
        else $error("status field does not show reference in use");

    a_fb_comp: assert property ( // RQ8
        ##1 fb_phase_comp_o == ($past(external_feedback_enable_q) ?
            $past(ext_fb_phase_i) : '0))
        else $error("feedback compensation does not follow enable");

    a_auto_keep: assert property ( // RQ16
        loop_operating_mode_q == MODE_AUTO && ref_locked_o && any_avail
        && !cur_leave && !cur_revert |=> $stable(active_ref_o))
        else $error("locked reference changed without a cause");

    a_prio_off: assert property ( // RQ16
        ref_priority_i[11:9] == PRIO_DISABLED |=> !ref_available_o[3])
        else $error("disabled reference reported as available");

    c_auto_switch: cover property (
        loop_operating_mode_q == MODE_AUTO && ref_locked_o ##1 $changed(active_ref_o));
    c_forced_fail: cover property (
        loop_operating_mode_q == MODE_FORCED && ref_locked_o ##1 holdover_o);
    c_auto_recover: cover property (
        loop_operating_mode_q == MODE_AUTO && holdover_o ##1 ref_locked_o);
    c_forced_masked: cover property (loop_operating_mode_q == MODE_FORCED
        && hold_fail == 4'h0 && switch_fail != 4'h0 ##1 ref_locked_o);

endmodule : dpll_mode_ref_select

// File: tb.sv
// self-checking testbench for the loop mode and reference select block
`timescale 1ns/1ps
module tb
    import dpll_mode_ref_select_pkg::*;
;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_n_i, psel, penable, pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata_o, rd;
    logic [3:0] pstrb, ref_available_o;
    logic [3:0] flt [4];
    logic [11:0] prio;
    logic [15:0] phase, fb_phase_comp_o;
    logic pready_o, pslverr_o, err, freerun_o, holdover_o, ref_locked_o, ext_fb_used_o;
    logic [1:0] active_ref_o;
    int failures, cmp_count, seed;

    // free running system clock, 8 ns period
    always #4 clk_sys_i = ~clk_sys_i;

    dpll_mode_ref_select #(.PHASE_W(16)) uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .signal_absent_fault_i(flt[0]), .single_cycle_fault_i(flt[1]),
        .coarse_frequency_fault_i(flt[2]), .guard_timer_fault_i(flt[3]),
        .ref_priority_i(prio), .ext_fb_phase_i(phase), .freerun_o(freerun_o),
        .holdover_o(holdover_o), .ref_locked_o(ref_locked_o), .active_ref_o(active_ref_o),
        .ref_available_o(ref_available_o), .ext_fb_used_o(ext_fb_used_o),
        .fb_phase_comp_o(fb_phase_comp_o)
    );

    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // best available reference: lowest number wins, ties go to the lowest index
    function automatic int best(input logic [11:0] p, input logic [3:0] av);
        int b = -1;
        for (int i = 0; i < 4; i++) begin
            if (av[i] && p[3*i+:3] != PRIO_DISABLED && (b < 0 || p[3*i+:3] < p[3*b+:3])) begin
                b = i;
            end
        end
        return b;
    endfunction : best

    // expected readback of the mode register, reserved bits read 011
    function automatic logic [31:0] mode_word(input logic [1:0] sel, input logic fb,
                                               input logic [1:0] m);
        return {24'h0, sel, fb, 3'b011, m};
    endfunction : mode_word

    // ----------------------------------------
    // apb master and helpers
    // ----------------------------------------
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 32);
        if (n >= 32) begin
            failures++;
            results();
        end else begin
            rd = prdata_o;
            err = pslverr_o;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wrreg(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask : wrreg

    task automatic rdreg(input logic [9:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask : rdreg

    // fault pins need three edges to reach the state outputs
    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
    endtask : settle

    // state code is {freerun, holdover, locked}
    task automatic look(input logic [2:0] s, input int a);
        chk("state", {29'h0, freerun_o, holdover_o, ref_locked_o}, {29'h0, s});
        chk("active ref", {30'h0, active_ref_o}, 32'(a));
    endtask : look

    task automatic set_flt(input int t, input logic [3:0] v);
        @(posedge clk_sys_i);
        flt[t] <= v;
        settle();
    endtask : set_flt

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int b, b2, r;
        seed = 62480;
        failures = 0;
        cmp_count = 0;
        rst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        prio = 12'h688;
        phase = 16'h0;
        for (int i = 0; i < 4; i++) flt[i] = 4'h0;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle();
        // reset values, unmapped access
        rdreg(ADDR_MODE_REFSEL);
        chk("mode reset", rd, {24'h0, RST_MODE_REFSEL});
        rdreg(ADDR_FAIL_MASK);
        chk("mask reset", rd, {24'h0, RST_FAIL_MASK});
        look(3'b001, 0);
        rdreg(10'h3fc);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        // automatic selection and switching, one fault type per trial
        wrreg(ADDR_FAIL_MASK, 32'hff);
        for (int t = 0; t < 4; t++) begin
            r = $random(seed) & 3;
            @(posedge clk_sys_i);
            for (int i = 0; i < 4; i++) prio[3*i+:3] <= 3'(((i + r) % 4) * 2);
            settle();
            b = best(prio, 4'hf);
            look(3'b001, b);
            set_flt(t, 4'h1 << b);
            b2 = best(prio, ~(4'h1 << b));
            look(3'b001, b2);
            chk("avail fault", {28'h0, ref_available_o}, {28'h0, ~(4'h1 << b)});
            rdreg(ADDR_MODE_REFSEL);
            chk("status", rd, mode_word(2'(b2), 1'b0, 2'b11));
            set_flt(t, 4'h0);
            look(3'b001, b);
            // masks keep bits 3:1 away from 100
            wrreg(ADDR_FAIL_MASK, 32'hff & ~(32'h11 << t));
            set_flt(t, 4'h1 << b);
            look(3'b001, b);
            chk("avail masked", {28'h0, ref_available_o}, 32'hf);
            set_flt(t, 4'h0);
            wrreg(ADDR_FAIL_MASK, 32'hff);
        end
        set_flt(0, 4'hf);
        look(3'b010, b);
        set_flt(0, 4'h0);
        // equal priorities on refs 0 and 1, refs 2 and 3 disabled
        @(posedge clk_sys_i);
        prio <= 12'hfc9;
        set_flt(0, 4'h1);
        look(3'b001, 1);
        set_flt(0, 4'h0);
        look(3'b001, 1);
        chk("avail disabled", {28'h0, ref_available_o}, 32'h3);
        set_flt(0, 4'h3);
        look(3'b010, 1);
        set_flt(0, 4'h0);
        @(posedge clk_sys_i);
        prio <= 12'h688;
        // forced reference for every select code
        for (int k = 0; k < 4; k++) begin
            wrreg(ADDR_MODE_REFSEL, mode_word(2'(k), 1'b0, 2'b10));
            settle();
            look(3'b001, k);
            rdreg(ADDR_MODE_REFSEL);
            chk("forced sel", rd, mode_word(2'(k), 1'b0, 2'b10));
            set_flt(0, 4'h1 << k);
            look(3'b010, k);
            set_flt(0, 4'h0);
        end
        // holdover enables all low keep the forced lock through a fault
        wrreg(ADDR_FAIL_MASK, 32'hf0);
        set_flt(1, 4'h8);
        look(3'b001, 3);
        chk("avail switch only", {28'h0, ref_available_o}, 32'h7);
        set_flt(1, 4'h0);
        wrreg(ADDR_FAIL_MASK, 32'hff);
        // forced holdover and freerun ignore the select field
        wrreg(ADDR_MODE_REFSEL, mode_word(2'd0, 1'b0, 2'b01));
        settle();
        look(3'b010, 3);
        wrreg(ADDR_MODE_REFSEL, mode_word(2'd2, 1'b0, 2'b00));
        settle();
        look(3'b100, 3);
        // automatic with feedback, then a select write that must not stick
        @(posedge clk_sys_i);
        phase <= 16'($random(seed));
        wrreg(ADDR_MODE_REFSEL, mode_word(2'd1, 1'b1, 2'b11));
        wrreg(ADDR_MODE_REFSEL, mode_word(2'd2, 1'b1, 2'b11));
        settle();
        look(3'b001, best(prio, 4'hf));
        rdreg(ADDR_MODE_REFSEL);
        chk("auto status", rd, mode_word(2'(best(prio, 4'hf)), 1'b1, 2'b11));
        chk("fb used", {31'h0, ext_fb_used_o}, 32'h1);
        chk("fb phase", {16'h0, fb_phase_comp_o}, {16'h0, phase});
        wrreg(ADDR_MODE_REFSEL, mode_word(2'd0, 1'b0, 2'b11));
        settle();
        chk("fb off", {31'h0, ext_fb_used_o}, 32'h0);
        chk("fb phase off", {16'h0, fb_phase_comp_o}, 32'h0);
        // write with byte strobe low leaves the mask alone
        apb(1'b1, ADDR_FAIL_MASK, 32'h0, 4'h0);
        rdreg(ADDR_FAIL_MASK);
        chk("strobe low", rd, 32'hff);
        results();
    end
endmodule : tb
